// ---- verilog/pwm_pkg.sv ----
// Purpose: shared constants and types of the single-slice pwm block
// Assumes: register index times four is the byte address on the bus
// Notes: offsets are word indices, data sits in the low byte
package pwm_pkg;
	// register indices
	localparam logic [11:0] IDX_PERIOD_LO = 12'h48f;
	localparam logic [11:0] IDX_PERIOD_HI = 12'h490;
	localparam logic [11:0] IDX_PRESCALE = 12'h491;
	localparam logic [11:0] IDX_IRQ_FLAGS = 12'h493;
	localparam logic [11:0] IDX_IRQ_ENABLE = 12'h494;
	localparam logic [11:0] IDX_CONTROL = 12'h495;
	localparam logic [11:0] IDX_CONFIG = 12'h496;
	localparam logic [11:0] IDX_P1_LO = 12'h497;
	localparam logic [11:0] IDX_P1_HI = 12'h498;
	localparam logic [11:0] IDX_P2_LO = 12'h499;
	localparam logic [11:0] IDX_P2_HI = 12'h49a;
	// control fields
	localparam int CTL_EN = 7;
	localparam int CTL_LD = 2;
	localparam int CTL_POL = 1;
	localparam int CTL_NOW = 0;
	// config fields
	localparam int CFG_OUT_ONE_POLARITY = 6;
	localparam int CFG_PUSH_PULL_ENABLE = 3;
	localparam logic [7:0] CFG_MASK = 8'hcf;
	// irq fields
	localparam int IRQ_P1 = 0;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [1:0] RST_IRQ = 2'h0;
	typedef enum logic [2:0] {
		MODE_LEFT = 3'h0,
		MODE_RIGHT = 3'h1,
		MODE_CENTER = 3'h2,
		MODE_VARIABLE = 3'h3,
		MODE_CMP_SET = 3'h4,
		MODE_CMP_TOGGLE = 3'h5
	} mode_t;
	typedef enum logic [1:0] {
		RUN_ACTIVE = 2'h0,
		RUN_DRAIN = 2'h1,
		RUN_STOPPED = 2'h3
	} run_t;
endpackage

// ---- verilog/pwm_time_if.sv ----
// Purpose: carries the time base between the slice and its timer
// Assumes: one clock domain
// Notes: tick marks one pwm clock
`timescale 1ns/1ps
interface pwm_time_if;
	logic run;
	logic [7:0] prescale;
	logic [15:0] period;
	logic tick;
	logic period_end;
	logic [15:0] timer;
	modport source (input run, input prescale, input period,
		output tick, output period_end, output timer);
	modport user (output run, output prescale, output period,
		input tick, input period_end, input timer);
endinterface

// ---- verilog/pwm_timebase.sv ----
// Purpose: prescaler and period counter of the pwm
// Assumes: run low clears both counters
// Notes: a period of zero behaves as one pwm clock
`timescale 1ns/1ps
module pwm_timebase (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// time base
	pwm_time_if.source t
);
	logic [7:0] pre_q, pre_d;
	logic [15:0] tmr_q, tmr_d;
	logic tick_c;
	logic [15:0] last;
	assign tick_c = t.run && (pre_q == t.prescale);
	assign last = (t.period == 16'h0000) ? 16'h0000 : t.period - 16'h0001;
	assign t.tick = tick_c;
	assign t.timer = tmr_q;
	assign t.period_end = tick_c && (tmr_q >= last);
	always_comb begin
		pre_d = pre_q + 8'h01;
		tmr_d = tmr_q;
		if (!t.run) begin
			pre_d = 8'h00;
			tmr_d = 16'h0000;
		end else if (tick_c) begin
			pre_d = 8'h00;
			tmr_d = (tmr_q >= last) ? 16'h0000 : tmr_q + 16'h0001;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= 8'h00;
			tmr_q <= 16'h0000;
		end else begin
			pre_q <= pre_d;
			tmr_q <= tmr_d;
		end
	end
endmodule

// ---- verilog/ext_reset_sync.sv ----
// Purpose: brings the external reset pin into hclk and applies its polarity
// Assumes: pin is asynchronous to hclk
// Notes: only the second stage is looked at
`timescale 1ns/1ps
module ext_reset_sync (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin and setting
	input wire logic pin,
	input wire logic active_low,
	output logic active
);
	logic s1_q, s2_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
		end
	end
	assign active = s2_q ^ active_low;
endmodule

// ---- verilog/pwm_slice.sv ----
// Purpose: control, mode logic and ahb-lite registers of one pwm slice
// Assumes: single slave on the bus, whole-word single transfers
// Notes: reads take one wait state so a write just before is seen
// Functional notes
// - enable bit 1 gates parameter two irq, bit 0 parameter one
// - enable low resets internal logic, outputs idle, registers kept
// - reload request copies period and parameters at period event, then clears
// - polarity bit one makes external reset active low, else high
// - immediate option stops counter next pwm clock, outputs inactive
// - otherwise counter finishes period, then stops, outputs inactive
// - polarity bit one makes the output low true; bit 7 two, 6 one
// - push-pull alternates the active output each period
// - mode field: left, right, center, variable aligned for both outputs
// - mode 101 toggles an output when timer equals its parameter
// - mode 100 sets an output high when timer equals its parameter
// - reserved modes 11x hold both outputs in reset state
// - compare match event when timer equals the 16-bit parameter
// - variable mode drives both outputs high at parameter one match
// - variable mode drives both outputs low at parameter two match
// - center mode: active twice the parameter, centred on period event
// - right mode: active parameter clocks at the end of the period
// - left mode: active parameter clocks at the start of the period
// - each parameter has separate low and high byte registers
// - flag events: match, output change, or pulse edge depending on mode
// - period counts period value pwm clocks of source over prescale plus one
`timescale 1ns/1ps
module pwm_slice (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pins
	input wire logic ext_reset_in,
	output logic slice_out_one,
	output logic slice_out_two,
	output logic irq
);
	pwm_time_if t();

	// bus state
	logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
	logic [11:0] addr_q, addr_d;
	logic hreadyout_q, hreadyout_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic accept;
	logic [7:0] wbyte, rbyte;

	// software registers
	logic [15:0] pr_q, pr_d;
	logic [7:0] pre_q, pre_d;
	logic [1:0] flags_q, flags_d, gie_q, gie_d;
	logic en_q, en_d, ld_q, ld_d, erpol_q, erpol_d, now_q, now_d;
	logic [7:0] cfg_q, cfg_d;
	logic [15:0] p1_q, p1_d, p2_q, p2_d;

	// active buffers and slice state
	logic [15:0] pr_act_q, pr_act_d;
	logic [15:0] p_act_q [2];
	logic [15:0] p_act_d [2];
	pwm_pkg::run_t run_q, run_d;
	logic phase_q, phase_d;
	logic [1:0] lvl_q, lvl_d, pin_q, pin_d, ev, match;
	logic irq_q, irq_d;
	logic reload, ext_act, stopped;
	pwm_pkg::mode_t mode;

	assign mode = pwm_pkg::mode_t'(cfg_q[2:0]);
	assign accept = hsel && htrans[1] && hready;
	assign wbyte = hwdata[7:0];
	// software load is kept pending until the counter wraps
	assign reload = en_q && ld_q && t.period_end;
	assign stopped = (run_q == pwm_pkg::RUN_STOPPED);

	ext_reset_sync u_ers (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(ext_reset_in),
		.active_low(erpol_q),
		.active(ext_act)
	);

	pwm_timebase u_tb (
		.hclk(hclk),
		.hresetn(hresetn),
		.t(t)
	);
	assign t.run = en_q && !stopped;
	assign t.prescale = pre_q;
	assign t.period = pr_act_q;

	// bus handshake: a read waits one cycle for its data
	always_comb begin
		wr_pend_d = accept && hwrite;
		rd_pend_d = accept && !hwrite;
		addr_d = accept ? haddr[13:2] : addr_q;
		hreadyout_d = !(accept && !hwrite);
		hrdata_d = rd_pend_q ? {24'h000000, rbyte} : hrdata_q;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 12'h000;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h00000000;
		end else begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			addr_q <= addr_d;
			hreadyout_q <= hreadyout_d;
			hrdata_q <= hrdata_d;
		end
	end
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;

	// read mux, unmapped reads as zero
	always_comb begin
		unique case (addr_q)
			pwm_pkg::IDX_PERIOD_LO: rbyte = pr_q[7:0];
			pwm_pkg::IDX_PERIOD_HI: rbyte = pr_q[15:8];
			pwm_pkg::IDX_PRESCALE: rbyte = pre_q;
			pwm_pkg::IDX_IRQ_FLAGS: rbyte = {6'h00, flags_q};
			pwm_pkg::IDX_IRQ_ENABLE: rbyte = {6'h00, gie_q};
			pwm_pkg::IDX_CONTROL: rbyte = {en_q, 4'h0, ld_q, erpol_q, now_q};
			pwm_pkg::IDX_CONFIG: rbyte = cfg_q;
			pwm_pkg::IDX_P1_LO: rbyte = p1_q[7:0];
			pwm_pkg::IDX_P1_HI: rbyte = p1_q[15:8];
			pwm_pkg::IDX_P2_LO: rbyte = p2_q[7:0];
			pwm_pkg::IDX_P2_HI: rbyte = p2_q[15:8];
			default: rbyte = 8'h00;
		endcase
	end

	// register file; hardware sets win over software writes
	always_comb begin
		pr_d = pr_q;
		pre_d = pre_q;
		gie_d = gie_q;
		en_d = en_q;
		erpol_d = erpol_q;
		now_d = now_q;
		cfg_d = cfg_q;
		p1_d = p1_q;
		p2_d = p2_q;
		flags_d = flags_q;
		ld_d = reload ? 1'b0 : ld_q;
		if (wr_pend_q) begin
			unique case (addr_q)
				pwm_pkg::IDX_PERIOD_LO: pr_d[7:0] = wbyte;
				pwm_pkg::IDX_PERIOD_HI: pr_d[15:8] = wbyte;
				pwm_pkg::IDX_PRESCALE: pre_d = wbyte;
				pwm_pkg::IDX_IRQ_FLAGS: flags_d = wbyte[1:0];
				pwm_pkg::IDX_IRQ_ENABLE: gie_d = wbyte[1:0];
				pwm_pkg::IDX_CONTROL: begin
					en_d = wbyte[pwm_pkg::CTL_EN];
					ld_d = wbyte[pwm_pkg::CTL_LD];
					erpol_d = wbyte[pwm_pkg::CTL_POL];
					now_d = wbyte[pwm_pkg::CTL_NOW];
				end
				// masked to the defined fields, otherwise taken as is
				pwm_pkg::IDX_CONFIG: cfg_d = wbyte & pwm_pkg::CFG_MASK;
				pwm_pkg::IDX_P1_LO: p1_d[7:0] = wbyte;
				pwm_pkg::IDX_P1_HI: p1_d[15:8] = wbyte;
				pwm_pkg::IDX_P2_LO: p2_d[7:0] = wbyte;
				pwm_pkg::IDX_P2_HI: p2_d[15:8] = wbyte;
				default: ;
			endcase
		end
		flags_d = flags_d | ev;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pr_q <= pwm_pkg::RST_WORD;
			pre_q <= pwm_pkg::RST_BYTE;
			flags_q <= pwm_pkg::RST_IRQ;
			gie_q <= pwm_pkg::RST_IRQ;
			en_q <= 1'b0;
			ld_q <= 1'b0;
			erpol_q <= 1'b0;
			now_q <= 1'b0;
			cfg_q <= pwm_pkg::RST_BYTE;
			p1_q <= pwm_pkg::RST_WORD;
			p2_q <= pwm_pkg::RST_WORD;
		end else begin
			pr_q <= pr_d;
			pre_q <= pre_d;
			flags_q <= flags_d;
			gie_q <= gie_d;
			en_q <= en_d;
			ld_q <= ld_d;
			erpol_q <= erpol_d;
			now_q <= now_d;
			cfg_q <= cfg_d;
			p1_q <= p1_d;
			p2_q <= p2_d;
		end
	end

	// active buffers, run state and push-pull phase
	always_comb begin
		pr_act_d = pr_act_q;
		p_act_d[0] = p_act_q[0];
		p_act_d[1] = p_act_q[1];
		// while disabled the buffers track the registers
		if (!en_q || reload) begin
			pr_act_d = pr_q;
			p_act_d[0] = p1_q;
			p_act_d[1] = p2_q;
		end
		phase_d = en_q ? (phase_q ^ t.period_end) : 1'b0;
		run_d = run_q;
		if (!en_q) begin
			run_d = pwm_pkg::RUN_ACTIVE;
		end else begin
			unique case (run_q)
				pwm_pkg::RUN_ACTIVE: begin
					if (ext_act && now_q && t.tick) begin
						run_d = pwm_pkg::RUN_STOPPED;
					end else if (ext_act && !now_q) begin
						run_d = pwm_pkg::RUN_DRAIN;
					end
				end
				pwm_pkg::RUN_DRAIN: begin
					if (t.period_end) begin
						run_d = pwm_pkg::RUN_STOPPED;
					end
				end
				pwm_pkg::RUN_STOPPED: begin
					if (!ext_act) begin
						run_d = pwm_pkg::RUN_ACTIVE;
					end
				end
				default: run_d = pwm_pkg::RUN_ACTIVE;
			endcase
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pr_act_q <= pwm_pkg::RST_WORD;
			p_act_q[0] <= pwm_pkg::RST_WORD;
			p_act_q[1] <= pwm_pkg::RST_WORD;
			phase_q <= 1'b0;
			run_q <= pwm_pkg::RUN_ACTIVE;
		end else begin
			pr_act_q <= pr_act_d;
			p_act_q[0] <= p_act_d[0];
			p_act_q[1] <= p_act_d[1];
			phase_q <= phase_d;
			run_q <= run_d;
		end
	end

	// per-output level, event and pin
	for (genvar i = 0; i < 2; i++) begin : g_out
		logic late, gate;
		assign match[i] = t.tick && (t.timer == p_act_q[i]);
		assign late = ({1'b0, t.timer} + {1'b0, p_act_q[i]}) >= {1'b0, pr_act_q};
		// alternating gate, applied to the level in every mode when push-pull is on
		assign gate = cfg_q[pwm_pkg::CFG_PUSH_PULL_ENABLE] ? (phase_q == i[0]) : 1'b1;
		always_comb begin
			lvl_d[i] = lvl_q[i];
			ev[i] = 1'b0;
			if (!en_q || stopped) begin
				lvl_d[i] = 1'b0;
			end else begin
				unique case (mode)
					pwm_pkg::MODE_LEFT: lvl_d[i] = t.timer < p_act_q[i];
					pwm_pkg::MODE_RIGHT: lvl_d[i] = late;
					pwm_pkg::MODE_CENTER: lvl_d[i] = late || (t.timer < p_act_q[i]);
					pwm_pkg::MODE_VARIABLE: begin
						if (match[1]) begin
							lvl_d[i] = 1'b0;
						end else if (match[0]) begin
							lvl_d[i] = 1'b1;
						end
					end
					pwm_pkg::MODE_CMP_SET: lvl_d[i] = lvl_q[i] | match[i];
					pwm_pkg::MODE_CMP_TOGGLE: lvl_d[i] = lvl_q[i] ^ match[i];
					default: lvl_d[i] = 1'b0;
				endcase
				unique case (mode)
					pwm_pkg::MODE_LEFT: ev[i] = lvl_q[i] && !lvl_d[i];
					pwm_pkg::MODE_RIGHT: ev[i] = !lvl_q[i] && lvl_d[i];
					pwm_pkg::MODE_CENTER: ev[i] = lvl_q[i] != lvl_d[i];
					pwm_pkg::MODE_VARIABLE, pwm_pkg::MODE_CMP_SET,
					pwm_pkg::MODE_CMP_TOGGLE: ev[i] = match[i];
					default: ev[i] = 1'b0;
				endcase
			end
			// gate the next level, not the registered one, so a pulse never spills past a wrap
			pin_d[i] = (lvl_d[i] && gate) ^ cfg_q[pwm_pkg::CFG_OUT_ONE_POLARITY + i];
		end
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				lvl_q[i] <= 1'b0;
				pin_q[i] <= 1'b0;
			end else begin
				lvl_q[i] <= lvl_d[i];
				pin_q[i] <= pin_d[i];
			end
		end
	end

	assign irq_d = |(flags_q & gie_q);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end
	assign irq = irq_q;
	assign slice_out_one = pin_q[0];
	assign slice_out_two = pin_q[1];
	sequence s_reload_hit;
		en_q && ld_q && t.period_end;
	endsequence
	sequence s_late_stop;
		en_q && !now_q && ext_act && run_q == pwm_pkg::RUN_DRAIN ##0 t.period_end;
	endsequence
	a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
		(flags_q[1] && gie_q[1]) || (flags_q[0] && gie_q[0]) |=> irq)
		else $error("irq missing for enabled flag");
	a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
		(gie_q == 2'h0) |=> !irq)
		else $error("irq raised while all enables are off");
	a_disable_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		!en_q ##1 !en_q |=> slice_out_one == $past(cfg_q[6]) && t.timer == 16'h0000)
		else $error("outputs not idle while disabled");
	a_reload_copy: assert property (@(posedge hclk) disable iff (!hresetn)
		s_reload_hit ##0 !wr_pend_q |=> !ld_q && pr_act_q == $past(pr_q) && p_act_q[0] == $past(p1_q))
		else $error("reload did not copy or clear");
	a_now_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		en_q && now_q && ext_act && t.tick && run_q == pwm_pkg::RUN_ACTIVE && $stable(en_q)
		|=> stopped ##1 lvl_q == 2'h0)
		else $error("immediate stop missed");
	a_late_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		s_late_stop |=> stopped || !en_q)
		else $error("counter did not stop at period end");
	a_reserved_off: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_q[2:1] == 2'h3 ##1 cfg_q[2:1] == 2'h3 |-> lvl_q == 2'h0)
		else $error("reserved mode drove an output");
	a_toggle_match: assert property (@(posedge hclk) disable iff (!hresetn)
		en_q && !stopped && mode == pwm_pkg::MODE_CMP_TOGGLE && match[0] |=> lvl_q[0] != $past(lvl_q[0]))
		else $error("toggle on match missed");
	a_left_width: assert property (@(posedge hclk) disable iff (!hresetn)
		en_q && !stopped && mode == pwm_pkg::MODE_LEFT |-> lvl_d[0] == (t.timer < p_act_q[0]))
		else $error("left aligned level wrong");
	a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		ev[1] |=> flags_q[1])
		else $error("event lost its flag");
	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
endmodule

// ---- tb/tb_pwm_slice.sv ----
// Purpose: self-checking bench for the single-slice pwm block
// Assumes: hready is the slave's own hreadyout, one slave on the bus
// Notes: pins are judged by counting high cycles over whole periods, so phase does not matter
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module tb_pwm_slice;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout;
	logic hresp;
	logic ext_reset_in;
	logic slice_out_one;
	logic slice_out_two;
	logic irq;
	int miscompares = 0;
	int comparisons = 0;
	int c1;
	int c2;
	logic [11:0] rst_idx [7] = '{pwm_pkg::IDX_IRQ_ENABLE, pwm_pkg::IDX_CONTROL,
		pwm_pkg::IDX_CONFIG, pwm_pkg::IDX_P1_LO, pwm_pkg::IDX_P1_HI, pwm_pkg::IDX_P2_LO,
		pwm_pkg::IDX_P2_HI};

	pwm_slice u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_reset_in(ext_reset_in),
		.slice_out_one(slice_out_one), .slice_out_two(slice_out_two), .irq(irq)
	);

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hready is looked at just before the edge so the registered value is never raced
	task automatic wait_ready();
		logic rdy;
		int n;
		n = 0;
		rdy = 1'b0;
		while (rdy !== 1'b1) begin
			@(negedge hclk);
			rdy = hreadyout;
			rd = hrdata;
			@(posedge hclk);
			n++;
			if (n > 50) begin
				miscompares++;
				report_and_stop();
			end
		end
	endtask

	task automatic bus(input logic [11:0] idx, input logic w, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {18'h0, idx, 2'h0};
		hwrite <= w;
		hsize <= 3'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_ready();
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask

	task automatic rchk(input string nm, input logic [11:0] idx, input logic [7:0] exp);
		bus(idx, 1'b0, 8'h00);
		`CHK(nm, {24'h0, exp}, rd)
	endtask

	task automatic count(input int n);
		c1 = 0;
		c2 = 0;
		repeat (n) begin
			@(negedge hclk);
			if (slice_out_one === 1'b1) c1++;
			if (slice_out_two === 1'b1) c2++;
			@(posedge hclk);
		end
	endtask

	// config is only touched with the module disabled, as software must
	task automatic mode_run(input logic [7:0] cfg, input logic [15:0] p1, input logic [15:0] p2,
		input logic [7:0] per, input logic [7:0] ctl, input int e1, input int e2);
		wr(pwm_pkg::IDX_CONTROL, 8'h00);
		wr(pwm_pkg::IDX_IRQ_FLAGS, 8'h00);
		wr(pwm_pkg::IDX_CONFIG, cfg);
		wr(pwm_pkg::IDX_P1_LO, p1[7:0]);
		wr(pwm_pkg::IDX_P1_HI, p1[15:8]);
		wr(pwm_pkg::IDX_P2_LO, p2[7:0]);
		wr(pwm_pkg::IDX_P2_HI, p2[15:8]);
		wr(pwm_pkg::IDX_PERIOD_LO, per);
		wr(pwm_pkg::IDX_PERIOD_HI, 8'h00);
		wr(pwm_pkg::IDX_PRESCALE, 8'h00);
		wr(pwm_pkg::IDX_CONTROL, ctl);
		repeat (24) @(posedge hclk);
		count(32);
		`CHK("slice_out_one active cycles", e1, c1)
		`CHK("slice_out_two active cycles", e2, c2)
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		ext_reset_in = 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rst_idx[i]) rchk("reset value", rst_idx[i], 8'h00);
		`CHK("hresp", 1'b0, hresp)
		wr(pwm_pkg::IDX_CONFIG, 8'hff);
		rchk("slice_config", pwm_pkg::IDX_CONFIG, 8'hcf);
		wr(pwm_pkg::IDX_CONTROL, 8'h7b);
		rchk("pwm_control", pwm_pkg::IDX_CONTROL, 8'h03);
		wr(pwm_pkg::IDX_IRQ_ENABLE, 8'hff);
		rchk("pwm_irq_enable", pwm_pkg::IDX_IRQ_ENABLE, 8'h03);
		wr(12'h49b, 8'hff);
		rchk("unmapped", 12'h49b, 8'h00);
		wr(pwm_pkg::IDX_P1_LO, 8'h34);
		wr(pwm_pkg::IDX_P1_HI, 8'h12);
		wr(pwm_pkg::IDX_P1_LO, 8'h56);
		rchk("param one high", pwm_pkg::IDX_P1_HI, 8'h12);
		rchk("param one low", pwm_pkg::IDX_P1_LO, 8'h56);
		mode_run(8'h00, 16'd3, 16'd5, 8'd8, 8'h80, 12, 20);
		// drain option: the period runs out, then the pins fall inactive
		ext_reset_in <= 1'b1;
		repeat (16) @(posedge hclk);
		count(32);
		`CHK("drain stop", 0, c1 + c2)
		ext_reset_in <= 1'b0;
		repeat (16) @(posedge hclk);
		count(32);
		`CHK("resume after release", 12, c1)
		wr(pwm_pkg::IDX_CONTROL, 8'h83);
		repeat (5) @(posedge hclk);
		count(8);
		`CHK("immediate stop", 0, c1 + c2)
		ext_reset_in <= 1'b1;
		repeat (16) @(posedge hclk);
		count(32);
		`CHK("low-true pin idle", 12, c1)
		// a new parameter waits for the reload request
		wr(pwm_pkg::IDX_P1_LO, 8'h05);
		repeat (16) @(posedge hclk);
		count(32);
		`CHK("no reload yet", 12, c1)
		wr(pwm_pkg::IDX_CONTROL, 8'h87);
		repeat (24) @(posedge hclk);
		count(32);
		`CHK("after reload", 20, c1)
		rchk("reload cleared", pwm_pkg::IDX_CONTROL, 8'h83);
		ext_reset_in <= 1'b0;
		mode_run(8'h00, 16'd3, 16'd5, 8'd16, 8'h80, 6, 10);
		mode_run(8'h01, 16'd3, 16'd5, 8'd8, 8'h80, 12, 20);
		mode_run(8'h02, 16'd2, 16'd3, 8'd8, 8'h80, 16, 24);
		mode_run(8'h03, 16'd2, 16'd6, 8'd8, 8'h80, 16, 16);
		mode_run(8'h04, 16'd3, 16'h0103, 8'd8, 8'h80, 32, 0);
		mode_run(8'h05, 16'd3, 16'd5, 8'd8, 8'h80, 16, 16);
		mode_run(8'h06, 16'd3, 16'd5, 8'd8, 8'h80, 0, 0);
		mode_run(8'h07, 16'd3, 16'd5, 8'd8, 8'h80, 0, 0);
		mode_run(8'h08, 16'd3, 16'd5, 8'd8, 8'h80, 6, 10);
		mode_run(8'h09, 16'd3, 16'd5, 8'd8, 8'h80, 6, 10);
		mode_run(8'hc0, 16'd3, 16'd5, 8'd8, 8'h80, 20, 12);
		mode_run(8'hc0, 16'd3, 16'd5, 8'd8, 8'h00, 32, 32);
		mode_run(8'h00, 16'd3, 16'd5, 8'd8, 8'h00, 0, 0);
		mode_run(8'h00, 16'd3, 16'd0, 8'd8, 8'h80, 12, 0);
		wr(pwm_pkg::IDX_IRQ_ENABLE, 8'h02);
		repeat (4) @(posedge hclk);
		`CHK("irq masked", 1'b0, irq)
		rchk("pwm_irq_flags", pwm_pkg::IDX_IRQ_FLAGS, 8'h01);
		wr(pwm_pkg::IDX_IRQ_ENABLE, 8'h01);
		repeat (4) @(posedge hclk);
		`CHK("irq raised", 1'b1, irq)
		wr(pwm_pkg::IDX_CONTROL, 8'h00);
		wr(pwm_pkg::IDX_IRQ_FLAGS, 8'h00);
		repeat (4) @(posedge hclk);
		`CHK("irq cleared", 1'b0, irq)
		report_and_stop();
	end
endmodule
